// *** design/flash_bus_cycle.sv ***
// One read or write cycle on the flash pins.
`timescale 1ns/100ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk_in,
    input  wire logic                reset_in,
    // Cycle request.
    input  wire logic                start_in,
    input  wire logic                write_in,
    input  wire logic [ADDR_W-1:0]   addr_in,
    input  wire logic [DATA_W-1:0]   wdata_in,
    output logic                     done_out,
    output logic [DATA_W-1:0]        rdata_out,
    // Flash pins.
    output logic                     chip_sel_n_out,
    output logic                     out_en_n_out,
    output logic                     write_en_n_out,
    output logic [ADDR_W-1:0]        addr_out,
    output logic [DATA_W-1:0]        dq_out,
    output logic                     dq_oe_out,
    input  wire logic [DATA_W-1:0]   dq_in
);
    typedef enum logic [1:0] {
        CY_IDLE  = 2'b00,
        CY_SETUP = 2'b01,
        CY_PULSE = 2'b11,
        CY_END   = 2'b10
    } cycle_state_e;

    cycle_state_e            st_q, st_d;
    logic [7:0]              cnt_q, cnt_d;
    logic                    wr_q, wr_d;
    logic                    cs_n_q, cs_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic                    dqoe_q, dqoe_d, done_q, done_d;
    logic [ADDR_W-1:0]       a_q, a_d;
    logic [DATA_W-1:0]       wd_q, wd_d, rd_q, rd_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        wr_d = wr_q;
        cs_n_d = cs_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        dqoe_d = dqoe_q;
        done_d = 1'b0;
        a_d = a_q;
        wd_d = wd_q;
        rd_d = rd_q;
        case (st_q)
            CY_IDLE: begin
                if (start_in) begin
                    // Address and data settle before any strobe falls.
                    wr_d = write_in;
                    a_d = addr_in;
                    wd_d = wdata_in;
                    dqoe_d = write_in;
                    st_d = CY_SETUP;
                end
            end
            CY_SETUP: begin
                // Strobes fall together once the address has settled.
                cs_n_d = 1'b0;
                we_n_d = ~wr_q;
                oe_n_d = wr_q;
                cnt_d = wr_q ? 8'(STROBE_CYC) : 8'(ACCESS_CYC);
                st_d = CY_PULSE;
            end
            CY_PULSE: begin
                if (cnt_q <= 8'h01) begin
                    // Write enable rises first while data is held.
                    we_n_d = 1'b1;
                    rd_d = dq_in;
                    oe_n_d = 1'b1;
                    st_d = CY_END;
                end else begin
                    cnt_d = cnt_q - 8'h01;
                end
            end
            CY_END: begin
                cs_n_d = 1'b1;
                dqoe_d = 1'b0;
                done_d = 1'b1;
                st_d = CY_IDLE;
            end
            default: st_d = CY_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= CY_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            cs_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            dqoe_q <= 1'b0;
            done_q <= 1'b0;
            a_q <= '0;
            wd_q <= '0;
            rd_q <= '0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wr_q <= wr_d;
            cs_n_q <= cs_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            dqoe_q <= dqoe_d;
            done_q <= done_d;
            a_q <= a_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
        end
    end

    assign done_out = done_q;
    assign rdata_out = rd_q;
    assign chip_sel_n_out = cs_n_q;
    assign out_en_n_out = oe_n_q;
    assign write_en_n_out = we_n_q;
    assign addr_out = a_q;
    assign dq_out = wd_q;
    assign dq_oe_out = dqoe_q;

    chk_no_drive_read: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !out_en_n_out |-> !dq_oe_out)
        else $error("Host drives data while flash outputs enabled.");
    chk_we_oe_excl: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !write_en_n_out |-> out_en_n_out && !chip_sel_n_out)
        else $error("Write strobe without chip select or with output enable.");
    chk_data_held: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(write_en_n_out) |-> dq_oe_out && !chip_sel_n_out)
        else $error("Data not held at write strobe rise.");
    chk_addr_at_fall: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $fell(write_en_n_out) |-> !chip_sel_n_out && $stable(addr_out))
        else $error("Address not settled when write strobes fell.");
    chk_pulse_width: assert property (
        @(posedge clk_in) disable iff (reset_in)
        $fell(write_en_n_out) |-> !write_en_n_out [*2])
        else $error("Write pulse shorter than two cycles.");
endmodule : flash_bus_cycle

// *** design/flash_host_ctrl.sv ***
// Host sequencer that issues command sequences to a parallel NOR flash.
`timescale 1ns/100ps
// Overview of operation
// - Caller erases sector before programming a byte.
// - Program is unlock triple then address/data.
// - Program writes AA, 55, A0, then data.
// - Sector erase ends with 30H at sector.
// - Chip erase ends with 10H at 5555H.
// - Questionable status reread two more times.
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int ERASE_TIMEOUT = ERASE_TIMEOUT_CYC
)(
    // Clock and reset.
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    // Command port.
    input  wire logic                      req_in,
    input  wire logic [2:0]                op_in,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_in,
    output logic                           ready_out,
    output logic                           done_out,
    output logic                           error_out,
    output logic [flash_host_pkg::DATA_W-1:0] rdata_out,
    output logic                           id_mode_out,
    // Flash pins.
    output logic                           chip_sel_n_out,
    output logic                           out_en_n_out,
    output logic                           write_en_n_out,
    output logic [flash_host_pkg::ADDR_W-1:0] flash_addr_out,
    output logic [flash_host_pkg::DATA_W-1:0] dq_out,
    output logic                           dq_oe_out,
    input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);
    import flash_host_pkg::*;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_ISSUE = 3'b001,
        S_WAIT  = 3'b011,
        S_POLL  = 3'b010,
        S_CHECK = 3'b110,
        S_SETTL = 3'b111,
        S_DONE  = 3'b101
    } host_state_e;

    host_state_e             st_q, st_d;
    logic [2:0]              op_q, op_d;
    logic [STEP_W-1:0]       step_q, step_d;
    logic [ADDR_W-1:0]       ta_q, ta_d;
    logic [DATA_W-1:0]       td_q, td_d, last_q, last_d, rd_q, rd_d;
    logic                    have_last_q, have_last_d;
    logic [1:0]              retry_q, retry_d;
    logic [CNT_W-1:0]        tmo_q, tmo_d;
    logic                    rdy_q, rdy_d, done_q, done_d, err_q, err_d;
    logic                    id_q, id_d;
    logic                    cy_start, cy_write, cy_done;
    logic [ADDR_W-1:0]       cy_addr;
    logic [DATA_W-1:0]       cy_data, cy_rdata;

    // Number of writes in the sequence of each operation.
    function automatic logic [STEP_W-1:0] seq_len(input logic [2:0] op);
        case (op)
            OP_PROGRAM: seq_len = 3'd4;
            OP_SECTOR:  seq_len = 3'd6;
            OP_CHIP:    seq_len = 3'd6;
            OP_ID_IN:   seq_len = 3'd3;
            OP_ID_OUT:  seq_len = 3'd1;
            default:    seq_len = 3'd0;
        endcase
    endfunction : seq_len

    // Address and data of each write in a command sequence.
    function automatic logic [ADDR_W+DATA_W-1:0] seq_word(
        input logic [2:0]        op,
        input logic [STEP_W-1:0] step,
        input logic [ADDR_W-1:0] ta,
        input logic [DATA_W-1:0] td
    );
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] d;
        a = UNLOCK_ADDR_A;
        d = UNLOCK_DATA_A;
        if (op == OP_ID_OUT) begin
            d = CMD_ID_EXIT;
        end else begin
            case (step)
                3'd0: d = UNLOCK_DATA_A;
                3'd1: begin
                    a = UNLOCK_ADDR_B;
                    d = UNLOCK_DATA_B;
                end
                3'd2: begin
                    case (op)
                        OP_PROGRAM: d = CMD_PROGRAM;
                        OP_ID_IN:   d = CMD_ID_ENTRY;
                        default:    d = CMD_ERASE_SET;
                    endcase
                end
                3'd3: begin
                    if (op == OP_PROGRAM) begin
                        a = ta;
                        d = td;
                    end
                end
                3'd4: begin
                    a = UNLOCK_ADDR_B;
                    d = UNLOCK_DATA_B;
                end
                3'd5: begin
                    if (op == OP_SECTOR) begin
                        a = {ta[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
                        d = CMD_SECTOR;
                    end else begin
                        d = CMD_CHIP;
                    end
                end
                default: d = UNLOCK_DATA_A;
            endcase
        end
        seq_word = {a, d};
    endfunction : seq_word

    logic [ADDR_W+DATA_W-1:0] word;
    logic                     is_erase, toggled, poll_ok;

    assign word = seq_word(op_q, step_q, ta_q, td_q);
    assign is_erase = (op_q == OP_SECTOR) || (op_q == OP_CHIP);
    assign toggled = have_last_q &&
        (cy_rdata[TOGGLE_BIT] != last_q[TOGGLE_BIT]);
    assign poll_ok = is_erase ? cy_rdata[POLL_BIT]
        : (cy_rdata[POLL_BIT] == td_q[POLL_BIT]);

    always_comb begin
        st_d = st_q;
        op_d = op_q;
        step_d = step_q;
        ta_d = ta_q;
        td_d = td_q;
        last_d = last_q;
        have_last_d = have_last_q;
        retry_d = retry_q;
        tmo_d = tmo_q;
        rd_d = rd_q;
        rdy_d = 1'b0;
        done_d = 1'b0;
        err_d = err_q;
        id_d = id_q;
        cy_start = 1'b0;
        cy_write = 1'b1;
        cy_addr = word[ADDR_W+DATA_W-1:DATA_W];
        cy_data = word[DATA_W-1:0];
        case (st_q)
            S_IDLE: begin
                rdy_d = ~req_in;
                if (req_in && rdy_q) begin
                    // Commands are only taken while idle.
                    op_d = op_in;
                    ta_d = addr_in;
                    td_d = data_in;
                    step_d = '0;
                    err_d = 1'b0;
                    have_last_d = 1'b0;
                    retry_d = 2'd0;
                    st_d = (op_in == OP_READ) ? S_POLL : S_ISSUE;
                end
            end
            S_ISSUE: begin
                cy_start = 1'b1;
                st_d = S_WAIT;
            end
            S_WAIT: begin
                if (cy_done) begin
                    if (step_q == seq_len(op_q) - 3'd1) begin
                        // Polling starts after the launching write.
                        tmo_d = is_erase ? CNT_W'(ERASE_TIMEOUT)
                                         : CNT_W'(PROG_MAX_CYC);
                        if (op_q == OP_ID_IN || op_q == OP_ID_OUT) begin
                            id_d = (op_q == OP_ID_IN);
                            st_d = S_DONE;
                        end else begin
                            st_d = S_POLL;
                        end
                    end else begin
                        step_d = step_q + 3'd1;
                        st_d = S_ISSUE;
                    end
                end
            end
            S_POLL: begin
                cy_start = 1'b1;
                cy_write = 1'b0;
                cy_addr = ta_q;
                st_d = S_CHECK;
            end
            S_CHECK: begin
                cy_write = 1'b0;
                cy_addr = ta_q;
                if (tmo_q != '0) begin
                    tmo_d = tmo_q - CNT_W'(1);
                end
                if (cy_done) begin
                    last_d = cy_rdata;
                    have_last_d = 1'b1;
                    rd_d = cy_rdata;
                    if (op_q == OP_READ) begin
                        st_d = S_DONE;
                    end else if (have_last_q && !toggled && poll_ok) begin
                        // Two confirming reads after the first stable one.
                        if (retry_q == 2'd2) begin
                            tmo_d = CNT_W'(SETTLE_CYC);
                            st_d = is_erase ? S_DONE : S_SETTL;
                        end else begin
                            retry_d = retry_q + 2'd1;
                            st_d = S_POLL;
                        end
                    end else if (tmo_q == '0) begin
                        err_d = 1'b1;
                        st_d = S_DONE;
                    end else begin
                        retry_d = 2'd0;
                        st_d = S_POLL;
                    end
                end
            end
            S_SETTL: begin
                if (tmo_q == '0) begin
                    st_d = S_DONE;
                end else begin
                    tmo_d = tmo_q - CNT_W'(1);
                end
            end
            S_DONE: begin
                done_d = 1'b1;
                st_d = S_IDLE;
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st_q <= S_IDLE;
            op_q <= OP_READ;
            step_q <= '0;
            ta_q <= '0;
            td_q <= '0;
            last_q <= '0;
            have_last_q <= 1'b0;
            retry_q <= 2'd0;
            tmo_q <= '0;
            rd_q <= '0;
            rdy_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            id_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            step_q <= step_d;
            ta_q <= ta_d;
            td_q <= td_d;
            last_q <= last_d;
            have_last_q <= have_last_d;
            retry_q <= retry_d;
            tmo_q <= tmo_d;
            rd_q <= rd_d;
            rdy_q <= rdy_d;
            done_q <= done_d;
            err_q <= err_d;
            id_q <= id_d;
        end
    end

    flash_bus_cycle u_cycle (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .start_in       (cy_start),
        .write_in       (cy_write),
        .addr_in        (cy_addr),
        .wdata_in       (cy_data),
        .done_out       (cy_done),
        .rdata_out      (cy_rdata),
        .chip_sel_n_out (chip_sel_n_out),
        .out_en_n_out   (out_en_n_out),
        .write_en_n_out (write_en_n_out),
        .addr_out       (flash_addr_out),
        .dq_out         (dq_out),
        .dq_oe_out      (dq_oe_out),
        .dq_in          (dq_in)
    );

    assign ready_out = rdy_q;
    assign done_out = done_q;
    assign error_out = err_q;
    assign rdata_out = rd_q;
    assign id_mode_out = id_q;

    chk_no_write_poll: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (st_q == S_POLL || st_q == S_CHECK) |-> write_en_n_out)
        else $error("Write strobe low during status polling.");
    chk_done_pulse: assert property (
        @(posedge clk_in) disable iff (reset_in)
        done_out |-> !ready_out ##1 !done_out)
        else $error("Done not a single pulse.");
    chk_settle_wait: assert property (
        @(posedge clk_in) disable iff (reset_in)
        (st_q == S_CHECK && st_d == S_SETTL) |=>
        (st_q == S_SETTL) [*8])
        else $error("Settling interval cut short.");
    cov_program: cover property (@(posedge clk_in)
        st_q == S_SETTL ##1 st_q == S_SETTL);
    cov_erase_done: cover property (@(posedge clk_in)
        done_out && !error_out && op_q == OP_SECTOR);
    cov_id_entry: cover property (@(posedge clk_in) $rose(id_mode_out));
endmodule : flash_host_ctrl

// *** design/flash_host_pkg.sv ***
// Constants shared by the parallel flash host controller.
package flash_host_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 19'h05555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 19'h02AAA;
    localparam logic [ADDR_W-1:0] ID_MFR_ADDR   = 19'h00000;
    localparam logic [ADDR_W-1:0] ID_DEV_ADDR   = 19'h00001;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 8'hAA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 8'h55;
    localparam logic [DATA_W-1:0] CMD_PROGRAM   = 8'hA0;
    localparam logic [DATA_W-1:0] CMD_ERASE_SET = 8'h80;
    localparam logic [DATA_W-1:0] CMD_SECTOR    = 8'h30;
    localparam logic [DATA_W-1:0] CMD_CHIP      = 8'h10;
    localparam logic [DATA_W-1:0] CMD_ID_ENTRY  = 8'h90;
    localparam logic [DATA_W-1:0] CMD_ID_EXIT   = 8'hF0;
    localparam logic [DATA_W-1:0] ERASED_BYTE   = 8'hFF;
    localparam int POLL_BIT   = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int SECTOR_LSB = 12;
    // Operation codes on the command port.
    localparam logic [2:0] OP_READ    = 3'h0;
    localparam logic [2:0] OP_PROGRAM = 3'h1;
    localparam logic [2:0] OP_SECTOR  = 3'h2;
    localparam logic [2:0] OP_CHIP    = 3'h3;
    localparam logic [2:0] OP_ID_IN   = 3'h4;
    localparam logic [2:0] OP_ID_OUT  = 3'h5;
    // Bus timing in nanoseconds and clock cycles at 25 MHz.
    localparam int CLK_NS       = 40;
    localparam int STROBE_NS    = 80;
    localparam int STROBE_CYC   = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS    = 80;
    localparam int ACCESS_CYC   = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_NS    = 1000;
    localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PROG_MAX_NS  = 20000;
    localparam int PROG_MAX_CYC = PROG_MAX_NS / CLK_NS;
    localparam int CNT_W        = 24;
    localparam int ERASE_TIMEOUT_CYC = 5000000;
    localparam int STEP_W = 3;
endpackage : flash_host_pkg

// *** sim/flash_dev_model.sv ***
// Behavioural parallel NOR flash that answers the host controller.
`timescale 1ns/100ps
module flash_dev_model #(
    parameter int         PROG_NS  = 4000,
    parameter int         ERASE_NS = 30000,
    parameter logic [7:0] MFR_CODE = 8'h3C,
    parameter logic [7:0] DEV_CODE = 8'hC3
)(
    // Flash pins.
    input  wire logic                              chip_sel_n_in,
    input  wire logic                              out_en_n_in,
    input  wire logic                              write_en_n_in,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    output logic [flash_host_pkg::DATA_W-1:0]      dq_out,
    output logic                                   dq_drv_out,
    // Fault injection: an erase that never ends.
    input  wire logic                              stuck_in
);
    import flash_host_pkg::*;
    // Identity codes above are arbitrary values.
    logic [7:0]        mem [int];
    logic [ADDR_W-1:0] lat_a;
    logic [7:0]        prog_d;
    logic              wr_act, tog, id_mode, erasing;
    int                step;
    realtime           t_fall, t_end;
    initial begin
        wr_act = 1'b0;
        tog = 1'b0;
        id_mode = 1'b0;
        erasing = 1'b0;
        step = 0;
        t_end = -1.0e6;
        dq_out = 8'h00;
    end
    assign dq_drv_out = !chip_sel_n_in && !out_en_n_in;
    function automatic logic busy();
        return (stuck_in && erasing) || $realtime < t_end;
    endfunction : busy
    function automatic logic [7:0] rd(input logic [ADDR_W-1:0] a);
        if (busy() && erasing) return {1'b0, tog, 6'h00};
        if (busy())
            return {~prog_d[7], tog, prog_d[5:0]};
        if (!erasing && $realtime < t_end + 1000.0)
            return {prog_d[7:6], ~prog_d[5:0]};
        if (id_mode && a == ID_MFR_ADDR) return MFR_CODE;
        if (id_mode && a == ID_DEV_ADDR) return DEV_CODE;
        return mem.exists(int'(a)) ? mem[int'(a)] : ERASED_BYTE;
    endfunction : rd
    task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic ha, hb;
        ha = a[14:0] == UNLOCK_ADDR_A[14:0];
        hb = a[14:0] == UNLOCK_ADDR_B[14:0];
        if (busy()) return;
        if (step == 0 && d == CMD_ID_EXIT) id_mode = 1'b0;
        if (step == 2 && ha && d == CMD_ID_EXIT) id_mode = 1'b0;
        if (step == 2 && ha && d == CMD_ID_ENTRY) id_mode = 1'b1;
        if (step == 7) begin
            mem[int'(a)] = rd(a) & d;
            prog_d = d;
            erasing = 1'b0;
            t_end = $realtime + PROG_NS;
        end
        if (step == 5 && ha && d == CMD_CHIP) begin
            mem.delete();
            erasing = 1'b1;
            t_end = $realtime + ERASE_NS;
        end
        if (step == 5 && d == CMD_SECTOR) begin
            foreach (mem[k])
                if ((k >> SECTOR_LSB) == (int'(a) >> SECTOR_LSB))
                    mem[k] = ERASED_BYTE;
            erasing = 1'b1;
            t_end = $realtime + ERASE_NS;
        end
        case (step)
            0: step = (ha && d == UNLOCK_DATA_A) ? 1 : 0;
            1, 4: step = (hb && d == UNLOCK_DATA_B) ? step + 1 : 0;
            2: step = !ha ? 0 : d == CMD_ERASE_SET ? 3 :
                      d == CMD_PROGRAM ? 7 : 0;
            3: step = (ha && d == UNLOCK_DATA_A) ? 4 : 0;
            default: step = 0;
        endcase
    endtask : cmd
    always @(negedge write_en_n_in or negedge chip_sel_n_in) begin
        if (!write_en_n_in && !chip_sel_n_in && out_en_n_in) begin
            lat_a = addr_in;
            t_fall = $realtime;
            wr_act = 1'b1;
        end
    end
    always @(posedge write_en_n_in or posedge chip_sel_n_in) begin
        if (wr_act) begin
            wr_act = 1'b0;
            if ($realtime - t_fall >= 5.0)
                cmd(lat_a, dq_in);
        end
    end
    always @(posedge out_en_n_in) begin
        if (!chip_sel_n_in && busy()) tog = ~tog;
    end
    always @(negedge out_en_n_in or negedge chip_sel_n_in or addr_in) begin
        dq_out = rd(addr_in);
    end
endmodule : flash_dev_model

// *** sim/flash_host_ctrl_tb.sv ***
// Self-checking testbench for the parallel flash host controller.
`timescale 1ns/100ps
module flash_host_ctrl_tb;
    import flash_host_pkg::*;
    localparam logic [7:0] MFR_ID = 8'h3C; // Arbitrary value.
    localparam logic [7:0] DEV_ID = 8'hC3; // Arbitrary value.
    logic              clk_in = 1'b0, reset_in = 1'b1, req_in = 1'b0;
    logic              stuck = 1'b0, ready_out, done_out, error_out;
    logic              id_mode_out, dq_oe_out, dev_drv;
    logic              chip_sel_n_out, out_en_n_out, write_en_n_out;
    logic [2:0]        op_in = OP_READ;
    logic [ADDR_W-1:0] addr_in = '0, flash_addr_out;
    logic [7:0]        data_in = '0, rdata_out, dq_out, dq_in, dev_dq;
    logic [7:0]        last_q = '0;
    int                fails = 0, num_checks = 0;
    always #20 clk_in = ~clk_in;
    assign dq_in = dq_oe_out ? dq_out : dev_drv ? dev_dq : ~last_q;
    always @(posedge clk_in) last_q <= dq_in;
    always @(posedge clk_in) begin
        if (dq_oe_out === 1'b1 && dev_drv === 1'b1) begin
            fails++;
            $display("[ERR] dq_contention exp 0 got 1");
        end
    end
    flash_host_ctrl #(.ERASE_TIMEOUT(2000)) dut_u (
        .clk_in(clk_in), .reset_in(reset_in), .req_in(req_in),
        .op_in(op_in), .addr_in(addr_in), .data_in(data_in),
        .ready_out(ready_out), .done_out(done_out), .error_out(error_out),
        .rdata_out(rdata_out), .id_mode_out(id_mode_out),
        .chip_sel_n_out(chip_sel_n_out), .out_en_n_out(out_en_n_out),
        .write_en_n_out(write_en_n_out), .flash_addr_out(flash_addr_out),
        .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dq_in(dq_in));
    flash_dev_model #(.MFR_CODE(MFR_ID), .DEV_CODE(DEV_ID)) flash_u (
        .chip_sel_n_in(chip_sel_n_out), .out_en_n_in(out_en_n_out),
        .write_en_n_in(write_en_n_out), .addr_in(flash_addr_out),
        .dq_in(dq_in), .dq_out(dev_dq), .dq_drv_out(dev_drv),
        .stuck_in(stuck));
    task automatic print_verdict();
        if (fails == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(inout int n);
        @(posedge clk_in);
        #1 n++;
    endtask : tick
    task automatic cmd(input logic [2:0] op, logic [ADDR_W-1:0] a,
                       logic [7:0] d);
        int n;
        n = 0;
        while (ready_out !== 1'b1 && n < 5000) tick(n);
        req_in = 1'b1;
        op_in = op;
        addr_in = a;
        data_in = d;
        @(posedge clk_in);
        #1 req_in = 1'b0;
        n = 0;
        while (done_out !== 1'b1 && n < 5000) tick(n);
        chk("done_out", 8'h01, {7'h00, done_out});
    endtask : cmd
    task automatic rd(input logic [ADDR_W-1:0] a, logic [7:0] e);
        cmd(OP_READ, a, 8'h00);
        chk("rdata_out", e, rdata_out);
    endtask : rd
    task automatic t_boot();
        chk("id_mode_out", 8'h00, {7'h00, id_mode_out});
        chk("strobes", 8'h07,
            {5'h00, chip_sel_n_out, out_en_n_out,
             write_en_n_out});
    endtask : t_boot
    task automatic t_program();
        rd(19'h01234, ERASED_BYTE);
        cmd(OP_PROGRAM, 19'h01234, 8'h5A);
        chk("error_out", 8'h00, {7'h00, error_out});
        cmd(OP_PROGRAM, 19'h02FFF, 8'hA5);
        rd(19'h01234, 8'h5A);
        rd(19'h02FFF, 8'hA5);
    endtask : t_program
    task automatic t_sector();
        cmd(OP_SECTOR, 19'h01FFF, 8'h00);
        chk("error_out", 8'h00, {7'h00, error_out});
        rd(19'h01234, ERASED_BYTE);
        rd(19'h02FFF, 8'hA5);
    endtask : t_sector
    task automatic t_chip();
        cmd(OP_CHIP, 19'h00000, 8'h00);
        chk("error_out", 8'h00, {7'h00, error_out});
        rd(19'h02FFF, ERASED_BYTE);
    endtask : t_chip
    task automatic t_ident();
        cmd(OP_ID_IN, 19'h00000, 8'h00);
        chk("id_mode_out", 8'h01, {7'h00, id_mode_out});
        rd(ID_MFR_ADDR, MFR_ID);
        rd(ID_DEV_ADDR, DEV_ID);
        cmd(OP_ID_OUT, 19'h00000, 8'h00);
        chk("id_mode_out", 8'h00, {7'h00, id_mode_out});
        rd(ID_MFR_ADDR, ERASED_BYTE);
    endtask : t_ident
    task automatic t_stuck();
        stuck = 1'b1;
        cmd(OP_SECTOR, 19'h05000, 8'h00);
        chk("error_out", 8'h01, {7'h00, error_out});
        stuck = 1'b0;
        rd(19'h05000, ERASED_BYTE);
        chk("error_out", 8'h00, {7'h00, error_out});
    endtask : t_stuck
    initial begin
        repeat (2) @(posedge clk_in);
        #1 reset_in = 1'b0;
        t_boot();
        t_program();
        t_sector();
        t_chip();
        t_ident();
        t_stuck();
        print_verdict();
    end
    initial begin
        #2000000;
        fails++;
        print_verdict();
    end
endmodule : flash_host_ctrl_tb
